// ==== inc/mcirq_pkg.sv ====
/*
  Constants, types and helpers shared by the MAC channel interrupt
  status and mask block.
  Assumes a 32-bit Avalon-MM register port with byte addresses.
*/
`default_nettype none

package mcirq_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned MCIRQ_CHANNELS = 8;
  localparam int unsigned MCIRQ_DATA_W = 32;
  localparam int unsigned MCIRQ_ADDR_W = 8;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] MCIRQ_OFS_TX_RAW = 8'h00;
  localparam logic [7:0] MCIRQ_OFS_TX_MASKED = 8'h04;
  localparam logic [7:0] MCIRQ_OFS_TX_MASK_SET = 8'h08;
  localparam logic [7:0] MCIRQ_OFS_TX_MASK_CLEAR = 8'h0C;
  localparam logic [7:0] MCIRQ_OFS_RX_RAW = 8'h10;
  localparam logic [7:0] MCIRQ_OFS_RX_MASKED = 8'h14;
  localparam logic [7:0] MCIRQ_OFS_RX_MASK_SET = 8'h18;
  localparam logic [7:0] MCIRQ_OFS_RX_MASK_CLEAR = 8'h1C;
  localparam logic [7:0] MCIRQ_OFS_SOURCE_VECTOR = 8'h20;
  localparam logic [7:0] MCIRQ_OFS_EVT_STATUS = 8'h24;
  localparam logic [7:0] MCIRQ_OFS_EVT_MASK = 8'h28;

  // ==========================================================
  // Source vector field positions
  localparam int unsigned MCIRQ_BIT_USER = 31;
  localparam int unsigned MCIRQ_BIT_LINK = 30;
  localparam int unsigned MCIRQ_BIT_HOST = 17;
  localparam int unsigned MCIRQ_BIT_STAT = 16;
  localparam int unsigned MCIRQ_RX_LSB = 8;
  localparam int unsigned MCIRQ_TX_LSB = 0;
  localparam logic [31:0] MCIRQ_VECTOR_USED = 32'hC003FFFF;

  // ==========================================================
  // Reset values
  localparam logic [31:0] MCIRQ_RST_WORD = 32'h00000000;
  localparam logic [7:0] MCIRQ_RST_MASK = 8'h00;

  // ==========================================================
  // Bus handshake states, Gray along idle -> ack -> idle
  typedef enum logic [1:0] {
    MCIRQ_ST_IDLE = 2'b00,
    MCIRQ_ST_ACK = 2'b01
  } mcirq_state_t;

  // Byte enables widened to a bit mask
  function automatic logic [31:0] mcirq_lane_mask(input logic [3:0] be);
    mcirq_lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : mcirq_lane_mask

endpackage : mcirq_pkg

`default_nettype wire

// ==== rtl/mcirq_event_sampler.sv ====
/*
  Registers the pending source vector and flags rising edges.
  Assumes pending inputs are synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none

module mcirq_event_sampler
  import mcirq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] level_in,
  output logic [31:0] level,
  output logic [31:0] rise
);

  logic [31:0] prev;
  logic [31:0] next_level;
  logic [31:0] next_prev;

  // ==========================================================
  // Sample and remember previous sample
  always_comb
  begin
    next_level = level_in;
    next_prev = level;
    rise = level & ~prev;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level <= MCIRQ_RST_WORD;
      prev <= MCIRQ_RST_WORD;
    end
    else
    begin
      level <= next_level;
      prev <= next_prev;
    end
  end

endmodule : mcirq_event_sampler

`default_nettype wire

// ==== rtl/mcirq_mask_reg.sv ====
/*
  Per-channel interrupt mask with write-one-to-set and
  write-one-to-clear strobes.
  Assumes set and clear strobes are one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none

module mcirq_mask_reg
  import mcirq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] set_bits,
  input wire logic [7:0] clear_bits,
  output logic [7:0] mask
);

  logic [7:0] next_mask;

  // ==========================================================
  // Ones set or clear, zeros keep
  always_comb
  begin
    next_mask = (mask | set_bits) & ~clear_bits;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mask <= MCIRQ_RST_MASK;
    end
    else
    begin
      mask <= next_mask;
    end
  end

endmodule : mcirq_mask_reg

`default_nettype wire

// ==== rtl/mcirq_top.sv ====
/*
  MAC channel interrupt status and mask block: per-channel masks for
  eight transmit and eight receive channels, raw and masked status,
  the combined source vector and a summary event interrupt.
  Assumes an Avalon-MM master with waitrequest on clk and synchronous
  pending inputs.
*/
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module mcirq_top
  import mcirq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] tx_pending_vector,
  input wire logic [7:0] rx_pending_vector,
  input wire logic host_error_pending,
  input wire logic statistics_pending,
  input wire logic mgmt_user_irq_pending,
  input wire logic mgmt_link_change_pending,
  output logic [7:0] tx_channel_irq,
  output logic [7:0] rx_channel_irq,
  output logic irq
);

  // ==========================================================
  // Declarations
  mcirq_state_t state;
  mcirq_state_t next_state;
  logic [31:0] next_readdata;
  logic next_waitrequest;

  logic [31:0] source_in;
  logic [31:0] irq_source_vector;
  logic [31:0] source_rise;

  logic [7:0] tx_irq_status_raw;
  logic [7:0] rx_irq_status_raw;
  logic [7:0] tx_irq_status_masked;
  logic [7:0] rx_irq_status_masked;
  logic [7:0] tx_channel_mask_bit;
  logic [7:0] rx_channel_mask_bit;

  logic [7:0] tx_mask_set_strobe;
  logic [7:0] tx_mask_clear_strobe;
  logic [7:0] rx_mask_set_strobe;
  logic [7:0] rx_mask_clear_strobe;

  logic [31:0] evt_status;
  logic [31:0] evt_mask;
  logic [31:0] next_evt_status;
  logic [31:0] next_evt_mask;
  logic [31:0] evt_clear;
  logic [31:0] evt_mask_wr;
  logic evt_mask_we;

  logic [7:0] next_tx_channel_irq;
  logic [7:0] next_rx_channel_irq;
  logic next_irq;

  logic [31:0] wr_lanes;
  logic [31:0] wr_bits;
  logic wr_commit;

  // ==========================================================
  // Source vector assembly
  always_comb
  begin
    source_in = MCIRQ_RST_WORD;
    source_in[MCIRQ_BIT_USER] = mgmt_user_irq_pending;
    source_in[MCIRQ_BIT_LINK] = mgmt_link_change_pending;
    source_in[MCIRQ_BIT_HOST] = host_error_pending;
    source_in[MCIRQ_BIT_STAT] = statistics_pending;
    source_in[MCIRQ_RX_LSB +: 8] = rx_pending_vector;
    source_in[MCIRQ_TX_LSB +: 8] = tx_pending_vector;
  end

  // Registered vector, zero after reset, bits 29..18 stay zero
  mcirq_event_sampler u_sampler (
    .clk(clk),
    .rst(rst),
    .level_in(source_in),
    .level(irq_source_vector),
    .rise(source_rise)
  );

  // ==========================================================
  // Raw and masked channel status
  always_comb
  begin
    tx_irq_status_raw = irq_source_vector[MCIRQ_TX_LSB +: 8];
    rx_irq_status_raw = irq_source_vector[MCIRQ_RX_LSB +: 8];
    tx_irq_status_masked = tx_irq_status_raw & tx_channel_mask_bit;
    rx_irq_status_masked = rx_irq_status_raw & rx_channel_mask_bit;
  end

  // ==========================================================
  // Write strobes, active in the ack cycle while waitrequest is low
  always_comb
  begin
    wr_commit = (state == MCIRQ_ST_ACK) && avs_write;
    wr_lanes = mcirq_lane_mask(avs_byteenable);
    wr_bits = avs_writedata & wr_lanes;
    tx_mask_set_strobe = 8'h00;
    tx_mask_clear_strobe = 8'h00;
    rx_mask_set_strobe = 8'h00;
    rx_mask_clear_strobe = 8'h00;
    evt_clear = MCIRQ_RST_WORD;
    evt_mask_we = 1'b0;
    evt_mask_wr = evt_mask;
    if (wr_commit)
    begin
      if (avs_address == MCIRQ_OFS_TX_MASK_SET)
      begin
        tx_mask_set_strobe = wr_bits[7:0];
      end
      else if (avs_address == MCIRQ_OFS_TX_MASK_CLEAR)
      begin
        tx_mask_clear_strobe = wr_bits[7:0];
      end
      else if (avs_address == MCIRQ_OFS_RX_MASK_SET)
      begin
        rx_mask_set_strobe = wr_bits[7:0];
      end
      else if (avs_address == MCIRQ_OFS_RX_MASK_CLEAR)
      begin
        rx_mask_clear_strobe = wr_bits[7:0];
      end
      else if (avs_address == MCIRQ_OFS_EVT_STATUS)
      begin
        evt_clear = wr_bits;
      end
      else if (avs_address == MCIRQ_OFS_EVT_MASK)
      begin
        evt_mask_we = 1'b1;
        evt_mask_wr = ((evt_mask & ~wr_lanes) | wr_bits) & MCIRQ_VECTOR_USED;
      end
    end
  end

  // ==========================================================
  // Channel masks
  mcirq_mask_reg u_tx_mask (
    .clk(clk),
    .rst(rst),
    .set_bits(tx_mask_set_strobe),
    .clear_bits(tx_mask_clear_strobe),
    .mask(tx_channel_mask_bit)
  );

  mcirq_mask_reg u_rx_mask (
    .clk(clk),
    .rst(rst),
    .set_bits(rx_mask_set_strobe),
    .clear_bits(rx_mask_clear_strobe),
    .mask(rx_channel_mask_bit)
  );

  // ==========================================================
  // Sticky events, a new edge wins over a clear
  always_comb
  begin
    next_evt_status = (evt_status & ~evt_clear)
      | (source_rise & MCIRQ_VECTOR_USED);
    next_evt_mask = evt_mask_we ? evt_mask_wr : evt_mask;
    next_irq = |(evt_status & evt_mask);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      evt_status <= MCIRQ_RST_WORD;
      evt_mask <= MCIRQ_RST_WORD;
      irq <= 1'b0;
    end
    else
    begin
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      irq <= next_irq;
    end
  end

  // ==========================================================
  // Channel interrupt outputs
  always_comb
  begin
    next_tx_channel_irq = tx_irq_status_masked;
    next_rx_channel_irq = rx_irq_status_masked;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_channel_irq <= MCIRQ_RST_MASK;
      rx_channel_irq <= MCIRQ_RST_MASK;
    end
    else
    begin
      tx_channel_irq <= next_tx_channel_irq;
      rx_channel_irq <= next_rx_channel_irq;
    end
  end

  // ==========================================================
  // Bus handshake: take request in idle, answer one cycle later
  always_comb
  begin
    next_state = state;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    case (state)
      MCIRQ_ST_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          next_state = MCIRQ_ST_ACK;
          next_waitrequest = 1'b0;
          next_readdata = MCIRQ_RST_WORD;
          if (avs_read)
          begin
            if (avs_address == MCIRQ_OFS_TX_RAW)
            begin
              next_readdata[7:0] = tx_irq_status_raw;
            end
            else if (avs_address == MCIRQ_OFS_TX_MASKED)
            begin
              next_readdata[7:0] = tx_irq_status_masked;
            end
            else if (avs_address == MCIRQ_OFS_TX_MASK_SET ||
                     avs_address == MCIRQ_OFS_TX_MASK_CLEAR)
            begin
              next_readdata[7:0] = tx_channel_mask_bit;
            end
            else if (avs_address == MCIRQ_OFS_RX_RAW)
            begin
              next_readdata[7:0] = rx_irq_status_raw;
            end
            else if (avs_address == MCIRQ_OFS_RX_MASKED)
            begin
              next_readdata[7:0] = rx_irq_status_masked;
            end
            else if (avs_address == MCIRQ_OFS_RX_MASK_SET ||
                     avs_address == MCIRQ_OFS_RX_MASK_CLEAR)
            begin
              next_readdata[7:0] = rx_channel_mask_bit;
            end
            else if (avs_address == MCIRQ_OFS_SOURCE_VECTOR)
            begin
              next_readdata = irq_source_vector;
            end
            else if (avs_address == MCIRQ_OFS_EVT_STATUS)
            begin
              next_readdata = evt_status;
            end
            else if (avs_address == MCIRQ_OFS_EVT_MASK)
            begin
              next_readdata = evt_mask;
            end
          end
        end
      end
      MCIRQ_ST_ACK:
      begin
        next_state = MCIRQ_ST_IDLE;
        next_waitrequest = 1'b1;
      end
      default:
      begin
        next_state = MCIRQ_ST_IDLE;
        next_waitrequest = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= MCIRQ_ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= MCIRQ_RST_WORD;
    end
    else
    begin
      state <= next_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

endmodule : mcirq_top

`default_nettype wire

// ==== tb/mcirq_asserts.sv ====
/*
  Port checker for mcirq_top: bus answer timing, source vector,
  raw and masked status and channel interrupts.
  Assumes it is bound to mcirq_top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module mcirq_asserts
  import mcirq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] tx_pending_vector,
  input wire logic [7:0] rx_pending_vector,
  input wire logic host_error_pending,
  input wire logic statistics_pending,
  input wire logic mgmt_user_irq_pending,
  input wire logic mgmt_link_change_pending,
  input wire logic [7:0] tx_channel_irq,
  input wire logic [7:0] rx_channel_irq
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans(logic [7:0] ofs);
    avs_read && !avs_waitrequest && avs_address == ofs;
  endsequence
  // ==========================================================
  // Bus answer
  ans_bound_a: assert property (s_req |-> ##[1:2] !avs_waitrequest)
    else $error("bus answer late");
  ans_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  // ==========================================================
  // Source vector
  vec_mgmt_a: assert property (
    s_ans(MCIRQ_OFS_SOURCE_VECTOR) |-> avs_readdata[31:30] ==
    {$past(mgmt_user_irq_pending, 2), $past(mgmt_link_change_pending, 2)})
    else $error("vector mgmt bits wrong");
  vec_mac_a: assert property (
    s_ans(MCIRQ_OFS_SOURCE_VECTOR) |-> avs_readdata[17:16] ==
    {$past(host_error_pending, 2), $past(statistics_pending, 2)})
    else $error("vector host or stat bit wrong");
  vec_chan_a: assert property (
    s_ans(MCIRQ_OFS_SOURCE_VECTOR) |-> avs_readdata[15:0] ==
    {$past(rx_pending_vector, 2), $past(tx_pending_vector, 2)})
    else $error("vector channel bits wrong");
  vec_resv_a: assert property (
    s_ans(MCIRQ_OFS_SOURCE_VECTOR) |-> avs_readdata[29:18] == 12'h000)
    else $error("vector reserved bits set");
  // ==========================================================
  // Status and channel interrupts
  rx_raw_a: assert property (
    s_ans(MCIRQ_OFS_RX_RAW) |->
    avs_readdata == {24'h000000, $past(rx_pending_vector, 2)})
    else $error("rx raw status wrong");
  tx_raw_a: assert property (
    s_ans(MCIRQ_OFS_TX_RAW) |->
    avs_readdata == {24'h000000, $past(tx_pending_vector, 2)})
    else $error("tx raw status wrong");
  rx_masked_a: assert property (
    s_ans(MCIRQ_OFS_RX_MASKED) |->
    avs_readdata == {24'h000000, rx_channel_irq})
    else $error("rx masked status wrong");
  tx_masked_a: assert property (
    s_ans(MCIRQ_OFS_TX_MASKED) |->
    avs_readdata == {24'h000000, tx_channel_irq})
    else $error("tx masked status wrong");
  rx_irq_a: assert property (
    (rx_channel_irq & ~$past(rx_pending_vector, 2)) == 8'h00)
    else $error("rx irq without pending");
  tx_irq_a: assert property (
    (tx_channel_irq & ~$past(tx_pending_vector, 2)) == 8'h00)
    else $error("tx irq without pending");
endmodule : mcirq_asserts
`default_nettype wire

// ==== tb/testbench.sv ====
/*
  Self-checking bench for mcirq_top: bus tasks, random pendings,
  mask, status and event interrupt checks.
  Assumes mcirq_pkg, the design and the checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench
  import mcirq_pkg::*;
;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic host_error_pending, statistics_pending;
  logic mgmt_user_irq_pending, mgmt_link_change_pending;
  logic [7:0] avs_address, tx_pending_vector, rx_pending_vector;
  logic [7:0] tx_channel_irq, rx_channel_irq, txm, rxm, a;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, d, seed;
  int miscompares, checks;

  mcirq_top dut (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_pending_vector(tx_pending_vector),
    .rx_pending_vector(rx_pending_vector),
    .host_error_pending(host_error_pending),
    .statistics_pending(statistics_pending),
    .mgmt_user_irq_pending(mgmt_user_irq_pending),
    .mgmt_link_change_pending(mgmt_link_change_pending),
    .tx_channel_irq(tx_channel_irq), .rx_channel_irq(rx_channel_irq),
    .irq(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] mupd(input logic [7:0] m,
    input logic clr, input logic [31:0] v, input logic [3:0] be);
    if (!be[0])
      return m;
    return clr ? (m & ~v[7:0]) : (m | v[7:0]);
  endfunction : mupd

  function automatic logic [31:0] vexp();
    return {mgmt_user_irq_pending, mgmt_link_change_pending, 12'h000,
      host_error_pending, statistics_pending, rx_pending_vector,
      tx_pending_vector};
  endfunction : vexp

  task automatic conclude();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] ad,
    input logic [31:0] wd, input logic [3:0] be);
    int n;
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 16);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
      miscompares++;
      conclude();
    end
  endtask : bus

  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, irq}, {31'h0, e});
    if (irq !== e)
      conclude();
  endtask : wait_irq

  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    {avs_read, avs_write, host_error_pending, statistics_pending} = '0;
    {mgmt_user_irq_pending, mgmt_link_change_pending} = '0;
    {avs_address, tx_pending_vector, rx_pending_vector} = '0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h00000000;
    {miscompares, checks} = '0;
    seed = 32'h00000005;
    {txm, rxm} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, MCIRQ_OFS_SOURCE_VECTOR, 32'hFFFFFFFF, 4'hF);
    for (int i = 0; i < 13; i++)
    begin
      bus(1'b0, 8'(i * 4), 32'h0, 4'hF);
      chk(rd, 32'h00000000);
    end
    $display("test reset values done");
    for (int i = 0; i < 32; i++)
    begin
      seed = lfsr(lfsr(seed));
      a = 8'h08 + {3'b000, seed[9], 1'b0, seed[8], 2'b00};
      d = {seed[15:0], seed[31:16]};
      bus(1'b1, a, d, seed[13:10]);
      if (a[4])
        rxm = mupd(rxm, a[2], d, seed[13:10]);
      else
        txm = mupd(txm, a[2], d, seed[13:10]);
      bus(1'b0, a ^ 8'h04, 32'h0, 4'hF);
      chk(rd, {24'h0, a[4] ? rxm : txm});
    end
    $display("test masks done");
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(lfsr(seed));
      @(posedge clk);
      {mgmt_user_irq_pending, mgmt_link_change_pending} <= seed[19:18];
      {host_error_pending, statistics_pending} <= seed[17:16];
      {rx_pending_vector, tx_pending_vector} <= seed[15:0];
      bus(1'b0, MCIRQ_OFS_SOURCE_VECTOR, 32'h0, 4'hF);
      chk(rd, vexp());
      bus(1'b0, MCIRQ_OFS_TX_RAW, 32'h0, 4'hF);
      chk(rd, {24'h0, tx_pending_vector});
      bus(1'b0, MCIRQ_OFS_RX_RAW, 32'h0, 4'hF);
      chk(rd, {24'h0, rx_pending_vector});
      bus(1'b0, MCIRQ_OFS_RX_MASKED, 32'h0, 4'hF);
      chk(rd, {24'h0, rx_pending_vector & rxm});
      bus(1'b0, MCIRQ_OFS_TX_MASKED, 32'h0, 4'hF);
      chk(rd, {24'h0, tx_pending_vector & txm});
      chk({16'h0, tx_channel_irq, rx_channel_irq},
        {16'h0, tx_pending_vector & txm, rx_pending_vector & rxm});
    end
    $display("test pendings done");
    @(posedge clk);
    {rx_pending_vector, tx_pending_vector} <= 16'h0000;
    {host_error_pending, statistics_pending} <= 2'b00;
    {mgmt_user_irq_pending, mgmt_link_change_pending} <= 2'b00;
    repeat (3) bus(1'b1, MCIRQ_OFS_EVT_STATUS, 32'hFFFFFFFF, 4'hF);
    bus(1'b1, MCIRQ_OFS_EVT_MASK, 32'h00000001, 4'hF);
    wait_irq(1'b0);
    @(posedge clk);
    tx_pending_vector <= 8'h01;
    wait_irq(1'b1);
    bus(1'b0, MCIRQ_OFS_EVT_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000001);
    bus(1'b1, MCIRQ_OFS_EVT_MASK, 32'h00000000, 4'hF);
    wait_irq(1'b0);
    bus(1'b1, MCIRQ_OFS_EVT_MASK, 32'h00000001, 4'hF);
    wait_irq(1'b1);
    bus(1'b1, MCIRQ_OFS_EVT_STATUS, 32'h00000001, 4'hF);
    wait_irq(1'b0);
    bus(1'b0, MCIRQ_OFS_EVT_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000000);
    bus(1'b1, MCIRQ_OFS_EVT_MASK, 32'hFFFFFFFF, 4'hF);
    bus(1'b1, MCIRQ_OFS_EVT_MASK, 32'h00000000, 4'h8);
    bus(1'b0, MCIRQ_OFS_EVT_MASK, 32'h0, 4'hF);
    chk(rd, MCIRQ_VECTOR_USED & 32'h00FFFFFF);
    $display("test event irq done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, MCIRQ_OFS_TX_MASK_SET, 32'h0, 4'hF);
    chk(rd, 32'h00000000);
    $display("test second reset done");
    conclude();
  end
endmodule : testbench

bind mcirq_top mcirq_asserts u_chk (
  .clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tx_pending_vector(tx_pending_vector),
  .rx_pending_vector(rx_pending_vector),
  .host_error_pending(host_error_pending),
  .statistics_pending(statistics_pending),
  .mgmt_user_irq_pending(mgmt_user_irq_pending),
  .mgmt_link_change_pending(mgmt_link_change_pending),
  .tx_channel_irq(tx_channel_irq), .rx_channel_irq(rx_channel_irq)
);
`default_nettype wire
